// ---- rtl/bpt_pkg.sv ----
// Overview of operation
// - Limit code: 3491 mV plus 9.985 mV steps
// - Voltage limit trip: FETs off, charge enable cleared
// - Bit 7 disables; resets to zero
// - Voltage above warning level raises host interrupt
// - Warning code: 3500 mV plus 10 mV steps
// - Current code times 102.5 mA, 2050 mA floor
// - Current limit trip: FETs off, charge enable cleared
// - Offset 0 resets and restores to 5Ah
// - Offset 1 resets and restores to 46h
// - Offset 2 resets and restores to 47h
// - Unmapped register reads return all ones
package bpt_pkg;

  // ==========================================================
  // Measurement carriers
  // ==========================================================
  typedef logic [23:0] bpt_meas_t;          // Microvolts or microamps

  // Threshold register: disable bit above 7-bit code
  typedef struct packed {
    logic       off;                        // 1 disables the check
    logic [6:0] code;                       // Threshold code
  } bpt_thr_t;

  // Comparator results, registered
  typedef struct packed {
    logic ovp;                              // Voltage at or over limit
    logic warn;                             // Voltage over warning level
    logic ocp;                              // Current at or over limit
  } bpt_trip_t;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0] OVP_LIMIT_ADDR = 8'h00;  // Voltage limit
  localparam logic [7:0] OVP_WARN_ADDR  = 8'h01;  // Voltage warning
  localparam logic [7:0] OCP_LIMIT_ADDR = 8'h02;  // Current limit
  localparam logic [7:0] UNMAPPED_DATA  = 8'hFF;  // Read of a hole

  localparam bpt_thr_t OVP_LIMIT_RST = 8'h5A;     // 4389.65 mV
  localparam bpt_thr_t OVP_WARN_RST  = 8'h46;     // 4200 mV
  localparam bpt_thr_t OCP_LIMIT_RST = 8'h47;     // 7277.5 mA

  // ==========================================================
  // Threshold scaling, in uV and uA
  // ==========================================================
  localparam bpt_meas_t OVP_BASE_UV  = 24'h3544B8; // 3491000 uV
  localparam bpt_meas_t OVP_STEP_UV  = 24'h002701; // 9985 uV
  localparam bpt_meas_t WARN_BASE_UV = 24'h3567E0; // 3500000 uV
  localparam bpt_meas_t WARN_STEP_UV = 24'h002710; // 10000 uV
  localparam bpt_meas_t OCP_BASE_UA  = 24'h000000; // No offset
  localparam bpt_meas_t OCP_STEP_UA  = 24'h019064; // 102500 uA
  localparam logic [6:0] OCP_MIN_CODE = 7'h14;     // 2050 mA floor

  // ==========================================================
  // Serial link constants
  // ==========================================================
  localparam logic [3:0] BYTE_BITS = 4'h8;         // Bits per byte
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A; // Arbitrary value

  // Serial slave states
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ACK_ADDR = 4'h2,
    ST_PTR      = 4'h3,
    ST_ACK_PTR  = 4'h4,
    ST_WDATA    = 4'h5,
    ST_ACK_W    = 4'h6,
    ST_RDATA    = 4'h7,
    ST_ACK_R    = 4'h8
  } bpt_state_t;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Linear code to physical threshold
  function automatic bpt_meas_t bpt_scale(input logic [6:0] code,
                                          input bpt_meas_t base,
                                          input bpt_meas_t step);
    bpt_meas_t wide_code;
    wide_code = {17'h00000, code};
    return base + wide_code * step;
  endfunction : bpt_scale

endpackage : bpt_pkg

// ---- rtl/bpt_threshold_cmp.sv ----
`timescale 1ns/1ps
module bpt_threshold_cmp (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire bpt_pkg::bpt_thr_t ovp_cfg,
  input  wire bpt_pkg::bpt_thr_t warn_cfg,
  input  wire bpt_pkg::bpt_thr_t ocp_cfg,
  input  wire bpt_pkg::bpt_meas_t vbat_uv,
  input  wire bpt_pkg::bpt_meas_t ibat_ua,
  output bpt_pkg::bpt_trip_t     trip
);
  import bpt_pkg::*;

  bpt_meas_t  ovp_level;                    // Decoded voltage limit
  bpt_meas_t  warn_level;                   // Decoded warning level
  bpt_meas_t  ocp_level;                    // Decoded current limit
  logic [6:0] ocp_code;                     // Clamped current code
  bpt_trip_t  next_trip;                    // Comparator outcome

  // ==========================================================
  // Decode and compare
  // ==========================================================
  // Thresholds follow the live register value, no staging
  always_comb begin
    ovp_level  = bpt_scale(ovp_cfg.code, OVP_BASE_UV, OVP_STEP_UV);
    warn_level = bpt_scale(warn_cfg.code, WARN_BASE_UV, WARN_STEP_UV);
    // Codes below the usable floor act as the floor
    ocp_code   = (ocp_cfg.code < OCP_MIN_CODE) ? OCP_MIN_CODE : ocp_cfg.code;
    ocp_level  = bpt_scale(ocp_code, OCP_BASE_UA, OCP_STEP_UA);
    next_trip.ovp  = !ovp_cfg.off && (vbat_uv >= ovp_level);
    next_trip.warn = !warn_cfg.off && (vbat_uv > warn_level);
    next_trip.ocp  = !ocp_cfg.off && (ibat_ua >= ocp_level);
  end

  // One register stage keeps the wide compare off the FET path
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trip <= '0;
    end else begin
      trip <= next_trip;
    end
  end

endmodule : bpt_threshold_cmp

// ---- rtl/bpt_protect_regs.sv ----
`timescale 1ns/1ps
module bpt_protect_regs #(
  parameter logic [6:0] DEV_ADDR = bpt_pkg::DEV_ADDR_DEFAULT  // Arbitrary value
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  input  wire logic               reg_rst,
  input  wire logic               charge_enable_set,
  input  wire bpt_pkg::bpt_meas_t vbat_uv,
  input  wire bpt_pkg::bpt_meas_t ibat_ua,
  output logic                    charge_enable_bit,
  output logic                    batt_fet_on,
  output logic                    switch_fets_on,
  output logic                    int_n
);
  import bpt_pkg::*;

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic scl_s1, scl_s2, scl_d;              // SCL stages and history
  logic sda_s1, sda_s2, sda_d;              // SDA stages and history
  logic scl_rise, scl_fall;                 // Clock edges
  logic start_seen, stop_seen;              // Bus conditions

  // Only the second stage and its history feed edge logic
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  always_comb begin
    scl_rise   = scl_s2 && !scl_d;
    scl_fall   = !scl_s2 && scl_d;
    start_seen = scl_s2 && scl_d && !sda_s2 && sda_d;
    stop_seen  = scl_s2 && scl_d && sda_s2 && !sda_d;
  end

  // ==========================================================
  // Register file
  // ==========================================================
  bpt_thr_t ovp_cfg, next_ovp_cfg;          // Voltage limit register
  bpt_thr_t warn_cfg, next_warn_cfg;        // Voltage warning register
  bpt_thr_t ocp_cfg, next_ocp_cfg;          // Current limit register
  logic       wr_strobe;                    // Byte write completes
  logic [7:0] wr_addr;                      // Target of that byte
  logic [7:0] wr_data;                      // Byte written

  // Read decode, holes answer all ones
  function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                          input bpt_thr_t r0,
                                          input bpt_thr_t r1,
                                          input bpt_thr_t r2);
    case (addr)
      OVP_LIMIT_ADDR: read_mux = r0;
      OVP_WARN_ADDR:  read_mux = r1;
      OCP_LIMIT_ADDR: read_mux = r2;
      default:        read_mux = UNMAPPED_DATA;
    endcase
  endfunction : read_mux

  // Reset command beats a write landing in the same cycle
  always_comb begin
    next_ovp_cfg  = ovp_cfg;
    next_warn_cfg = warn_cfg;
    next_ocp_cfg  = ocp_cfg;
    if (reg_rst) begin
      next_ovp_cfg  = OVP_LIMIT_RST;
      next_warn_cfg = OVP_WARN_RST;
      next_ocp_cfg  = OCP_LIMIT_RST;
    end else if (wr_strobe) begin
      // Writes to holes are dropped
      case (wr_addr)
        OVP_LIMIT_ADDR: next_ovp_cfg  = wr_data;
        OVP_WARN_ADDR:  next_warn_cfg = wr_data;
        OCP_LIMIT_ADDR: next_ocp_cfg  = wr_data;
        default:        next_ovp_cfg  = ovp_cfg;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ovp_cfg  <= OVP_LIMIT_RST;
      warn_cfg <= OVP_WARN_RST;
      ocp_cfg  <= OCP_LIMIT_RST;
    end else begin
      ovp_cfg  <= next_ovp_cfg;
      warn_cfg <= next_warn_cfg;
      ocp_cfg  <= next_ocp_cfg;
    end
  end

  // ==========================================================
  // Serial slave
  // ==========================================================
  bpt_state_t state, next_state;            // Protocol position
  logic [3:0] bit_cnt, next_bit_cnt;        // Bits of current byte
  logic [7:0] shift_in, next_shift_in;      // Received bits
  logic [7:0] shift_out, next_shift_out;    // Bits still to send
  logic [7:0] ptr, next_ptr;                // Register pointer
  logic       rd_dir, next_rd_dir;          // Read transfer
  logic       nack, next_nack;              // Master declined more
  logic       next_sda_oe;                  // Pull SDA low

  // Sample on SCL rise, change SDA only on SCL fall
  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shift_in  = shift_in;
    next_shift_out = shift_out;
    next_ptr       = ptr;
    next_rd_dir    = rd_dir;
    next_nack      = nack;
    next_sda_oe    = sda_oe;
    wr_strobe      = 1'b0;
    wr_addr        = ptr;
    wr_data        = shift_in;
    if (start_seen) begin
      // Repeated start restarts from the address byte
      next_state   = ST_ADDR;
      next_bit_cnt = '0;
      next_sda_oe  = 1'b0;
    end else if (stop_seen) begin
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_sda_oe = 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            next_shift_in = {shift_in[6:0], sda_s2};
            next_bit_cnt  = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BYTE_BITS) begin
            next_sda_oe = 1'b1;
            if (state == ST_ADDR) begin
              next_rd_dir = shift_in[0];
              if (shift_in[7:1] == DEV_ADDR) begin
                next_state = ST_ACK_ADDR;
              end else begin
                // Other device addressed, stay off the bus
                next_state  = ST_IDLE;
                next_sda_oe = 1'b0;
              end
            end else if (state == ST_PTR) begin
              next_ptr   = shift_in;
              next_state = ST_ACK_PTR;
            end else begin
              // Byte complete: lands in the register now
              wr_strobe  = 1'b1;
              next_ptr   = ptr + 8'h01;
              next_state = ST_ACK_W;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            next_bit_cnt = '0;
            if (rd_dir) begin
              next_shift_out = read_mux(ptr, ovp_cfg, warn_cfg, ocp_cfg);
              next_sda_oe    = !next_shift_out[7];
              next_state     = ST_RDATA;
            end else begin
              next_sda_oe = 1'b0;
              next_state  = ST_PTR;
            end
          end
        end
        ST_ACK_PTR, ST_ACK_W: begin
          if (scl_fall) begin
            next_bit_cnt = '0;
            next_sda_oe  = 1'b0;
            next_state   = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == BYTE_BITS) begin
              // Release SDA for the master's acknowledge
              next_sda_oe = 1'b0;
              next_ptr    = ptr + 8'h01;
              next_state  = ST_ACK_R;
            end else begin
              next_shift_out = {shift_out[6:0], 1'b1};
              next_sda_oe    = !shift_out[6];
            end
          end
        end
        ST_ACK_R: begin
          if (scl_rise) begin
            next_nack = sda_s2;
          end else if (scl_fall) begin
            next_bit_cnt = '0;
            if (nack) begin
              next_state = ST_IDLE;
            end else begin
              next_shift_out = read_mux(ptr, ovp_cfg, warn_cfg, ocp_cfg);
              next_sda_oe    = !next_shift_out[7];
              next_state     = ST_RDATA;
            end
          end
        end
        default: begin
          next_state  = ST_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state     <= ST_IDLE;
      bit_cnt   <= '0;
      shift_in  <= '0;
      shift_out <= '0;
      ptr       <= '0;
      rd_dir    <= 1'b0;
      nack      <= 1'b0;
      sda_oe    <= 1'b0;
      sda_out   <= 1'b0;
    end else begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      shift_in  <= next_shift_in;
      shift_out <= next_shift_out;
      ptr       <= next_ptr;
      rd_dir    <= next_rd_dir;
      nack      <= next_nack;
      sda_oe    <= next_sda_oe;
      sda_out   <= 1'b0;                    // Open drain only pulls low
    end
  end

  // ==========================================================
  // Protection actions
  // ==========================================================
  bpt_trip_t trip;                          // Registered comparisons
  logic      next_charge_enable;            // Charge enable next

  bpt_threshold_cmp u_cmp (
    .clk      (clk),
    .nrst     (nrst),
    .ovp_cfg  (ovp_cfg),
    .warn_cfg (warn_cfg),
    .ocp_cfg  (ocp_cfg),
    .vbat_uv  (vbat_uv),
    .ibat_ua  (ibat_ua),
    .trip     (trip)
  );

  // A trip wins over a set; the host must not re-enable into a fault
  always_comb begin
    next_charge_enable = charge_enable_bit;
    if (trip.ovp || trip.ocp) begin
      next_charge_enable = 1'b0;
    end else if (charge_enable_set) begin
      next_charge_enable = 1'b1;
    end
  end

  // FETs follow charge enable, so a trip shuts both at once
  always_ff @(posedge clk) begin
    if (!nrst) begin
      charge_enable_bit <= 1'b0;
      batt_fet_on       <= 1'b0;
      switch_fets_on    <= 1'b0;
      int_n             <= 1'b1;
    end else begin
      charge_enable_bit <= next_charge_enable;
      batt_fet_on       <= next_charge_enable;
      switch_fets_on    <= next_charge_enable;
      int_n             <= !trip.warn;
    end
  end

endmodule : bpt_protect_regs

// ---- verification/bpt_i2c_host.sv ----
`timescale 1ns/1ps
// ==========================================================
// Serial bus host model, open-drain data line
// ==========================================================
module bpt_i2c_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // Arbitrary value
) (
  input  wire logic clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_low
);
  // Idle bus at time zero, both lines released
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // Everything paced on falling edges, away from the sampling edge
  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask : pause
  // Data moves only in the low phase; phases kept at five cycles
  task automatic xbit(input logic b, output logic r);
    pause(2);
    sda_low = !b;
    pause(3);
    scl = 1'b1;
    pause(3);
    r = sda_in;
    pause(2);
    scl = 1'b0;
  endtask : xbit
  // Data edge while the clock is high: start when a=0 b=1, stop when a=1 b=0
  task automatic frame(input logic a, input logic b);
    pause(2);
    sda_low = a;
    pause(3);
    scl = 1'b1;
    pause(5);
    sda_low = b;
    pause(5);
  endtask : frame
  // Eight bits MSB first, then the acknowledge slot
  task automatic xbyte(input logic [7:0] dv, input logic ack_in, output logic [7:0] q,
                       output logic ack);
    for (int i = 7; i >= 0; i--) begin
      xbit(dv[i], q[i]);
    end
    xbit(ack_in, ack);
  endtask : xbyte
  // Pointer write then one data byte
  task automatic wr(input logic [7:0] ptr, input logic [7:0] dv, output logic nak);
    logic [7:0] q;
    logic       a0, a1, a2;
    frame(1'b0, 1'b1);
    scl = 1'b0;
    xbyte({DEV_ADDR, 1'b0}, 1'b1, q, a0);
    xbyte(ptr, 1'b1, q, a1);
    xbyte(dv, 1'b1, q, a2);
    frame(1'b1, 1'b0);
    nak = a0 | a1 | a2;
  endtask : wr
  // Pointer, repeated start, one byte read and refused with a NACK
  task automatic rd(input logic [7:0] ptr, output logic [7:0] dv, output logic nak);
    logic [7:0] q;
    logic       a0, a1, a2, a3;
    frame(1'b0, 1'b1);
    scl = 1'b0;
    xbyte({DEV_ADDR, 1'b0}, 1'b1, q, a0);
    xbyte(ptr, 1'b1, q, a1);
    frame(1'b0, 1'b1);
    scl = 1'b0;
    xbyte({DEV_ADDR, 1'b1}, 1'b1, q, a2);
    xbyte(8'hFF, 1'b1, dv, a3);
    frame(1'b1, 1'b0);
    nak = a0 | a1 | a2;
  endtask : rd
endmodule : bpt_i2c_host

// ---- verification/bpt_protect_regs_asserts.sv ----
`timescale 1ns/1ps
// ==========================================================
// Port checker for the protection register bank
// ==========================================================
module bpt_protect_regs_chk (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               reg_rst,
  input wire logic               charge_enable_set,
  input wire bpt_pkg::bpt_meas_t vbat_uv,
  input wire bpt_pkg::bpt_meas_t ibat_ua,
  input wire logic               charge_enable_bit,
  input wire logic               batt_fet_on,
  input wire logic               switch_fets_on,
  input wire logic               int_n
);
  import bpt_pkg::*;
  // Reset-code thresholds; only these are known right after a register reset
  localparam bpt_meas_t OVP_DEF_UV  = 24'h42FB12;  // 4389.65 mV
  localparam bpt_meas_t WARN_DEF_UV = 24'h401640;  // 4200 mV
  localparam bpt_meas_t OCP_DEF_UA  = 24'h6F0BBC;  // 7277.5 mA
  localparam bpt_meas_t OVP_MIN_UV  = 24'h3544B8;  // Lowest voltage limit
  localparam bpt_meas_t OCP_MIN_UA  = 24'h1F47D0;  // Lowest current limit
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Assertions
  // ==========================================================
  chk_fets_follow: assert property (
    batt_fet_on == charge_enable_bit && switch_fets_on == charge_enable_bit)
    else $error("fet drive differs from charge enable");
  chk_enable_cause: assert property ($rose(charge_enable_bit) |-> $past(charge_enable_set))
    else $error("charge enable rose without a set request");
  chk_ovp_default: assert property (
    reg_rst ##1 (vbat_uv >= OVP_DEF_UV) |-> ##2 !charge_enable_bit)
    else $error("default voltage limit did not trip");
  chk_ocp_default: assert property (
    reg_rst ##1 (ibat_ua >= OCP_DEF_UA) |-> ##2 !charge_enable_bit)
    else $error("default current limit did not trip");
  chk_warn_default: assert property (reg_rst ##1 (vbat_uv > WARN_DEF_UV) |-> ##2 !int_n)
    else $error("default warning did not interrupt");
  chk_warn_quiet: assert property (reg_rst ##1 (vbat_uv <= WARN_DEF_UV) |-> ##2 int_n)
    else $error("interrupt at or below default warning");
  chk_no_trip_low: assert property (
    (vbat_uv < OVP_MIN_UV && ibat_ua < OCP_MIN_UA)[*3] ##0 charge_enable_bit
    |=> charge_enable_bit)
    else $error("charge enable cleared below every limit");
  chk_reset_quiet: assert property (disable iff (1'b0) !nrst |=> int_n && !charge_enable_bit)
    else $error("outputs active during reset");
endmodule : bpt_protect_regs_chk

bind bpt_protect_regs bpt_protect_regs_chk u_chk (
  .clk (clk), .nrst (nrst), .reg_rst (reg_rst), .charge_enable_set (charge_enable_set),
  .vbat_uv (vbat_uv), .ibat_ua (ibat_ua), .charge_enable_bit (charge_enable_bit),
  .batt_fet_on (batt_fet_on), .switch_fets_on (switch_fets_on), .int_n (int_n)
);

// ---- verification/battery_protect_threshold_regs_tb.sv ----
`timescale 1ns/1ps
module battery_protect_threshold_regs_tb;
  import bpt_pkg::*;
  // ==========================================================
  // Signals
  // ==========================================================
  logic       clk, nrst, reg_rst, ce_set;  // Bench-driven controls
  bpt_meas_t  vbat, ibat;                   // Measurements
  logic       scl, host_low, sda;           // Bus; host pulls low
  logic       sda_oe, sda_out;              // Device data drive
  logic       ceb, fet, sw, int_n;          // Protection outputs
  logic [7:0] d;                            // Read byte
  logic       nak;                          // Any refused byte
  int         n_fail, compares;             // Tallies
  // Pulled-up line, low when either party pulls
  assign sda = host_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);
  localparam bpt_meas_t OVP_DEF  = OVP_BASE_UV + 24'h00005A * OVP_STEP_UV;
  localparam bpt_meas_t WARN_DEF = WARN_BASE_UV + 24'h000046 * WARN_STEP_UV;
  localparam bpt_meas_t OCP_DEF  = 24'h000047 * OCP_STEP_UA;
  localparam bpt_meas_t LOW_V    = 24'h300000;  // Below every voltage limit
  typedef struct { bpt_meas_t v; bpt_meas_t i; logic ce; logic irq_n; } bpt_row_t;
  // Reset thresholds: voltage, current, then expected enable and interrupt
  bpt_row_t rows [6] = '{'{WARN_DEF, 24'h000000, 1'b1, 1'b1},
    '{WARN_DEF + 24'h000001, 24'h000000, 1'b1, 1'b0}, '{OVP_DEF - 24'h000001, 24'h000000, 1'b1, 1'b0},
    '{OVP_DEF, 24'h000000, 1'b0, 1'b0}, '{WARN_DEF, OCP_DEF - 24'h000001, 1'b1, 1'b1},
    '{WARN_DEF, OCP_DEF, 1'b0, 1'b1}};
  bpt_protect_regs u_dut (
    .clk (clk), .nrst (nrst), .scl_in (scl), .sda_in (sda), .sda_out (sda_out),
    .sda_oe (sda_oe), .reg_rst (reg_rst), .charge_enable_set (ce_set), .vbat_uv (vbat),
    .ibat_ua (ibat), .charge_enable_bit (ceb), .batt_fet_on (fet), .switch_fets_on (sw),
    .int_n (int_n));
  bpt_i2c_host u_host (.clk (clk), .sda_in (sda), .scl (scl), .sda_low (host_low));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  // Set measurements, let the two-stage trip path settle, then request charge enable
  // A set taken while an old trip is still registered is lost, hence the wait
  task automatic apply(input bpt_meas_t v, input bpt_meas_t i, input logic ce, input logic irq);
    @(negedge clk);
    vbat = v;
    ibat = i;
    repeat (2) @(negedge clk);
    ce_set = 1'b1;
    @(negedge clk);
    ce_set = 1'b0;
    repeat (3) @(negedge clk);
    check(ceb, ce, "charge enable");
    check({fet, sw}, {ce, ce}, "fet drive");
    check(int_n, irq, "interrupt");
  endtask : apply
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_host.wr(a, v, nak);
    check(nak, 1'b0, "write refused");
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, d, nak);
    check(nak, 1'b0, "read refused");
    check(d, e, "read value");
  endtask : rdchk
  // Register reset pulse with measurements already in place
  task automatic pulse_rst(input bpt_meas_t v, input bpt_meas_t i);
    @(negedge clk);
    vbat = v;
    ibat = i;
    @(negedge clk);
    reg_rst = 1'b1;
    @(negedge clk);
    reg_rst = 1'b0;
    repeat (3) @(negedge clk);
  endtask : pulse_rst
  task automatic conclude();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // Watchdog, roughly eleven times the expected run
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    conclude();
  end
  // ==========================================================
  // Sequence
  // ==========================================================
  initial begin
    {nrst, reg_rst, ce_set, vbat, ibat} = '0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    foreach (rows[k]) apply(rows[k].v, rows[k].i, rows[k].ce, rows[k].irq_n);
    $display("test rows done");
    rdchk(8'h00, 8'h5A);
    rdchk(8'h01, 8'h46);
    rdchk(8'h02, 8'h47);
    rdchk(8'h03, 8'hFF);
    rdchk(8'hC5, 8'hFF);
    wr(8'h03, 8'h12);
    rdchk(8'h03, 8'hFF);
    $display("test map done");
    wr(8'h00, 8'hDA);
    rdchk(8'h00, 8'hDA);
    apply(OVP_DEF + 24'h010000, 24'h000000, 1'b1, 1'b0);
    wr(8'h00, 8'h01);
    check(ceb, 1'b0, "trip on new limit");
    apply(OVP_BASE_UV + OVP_STEP_UV - 24'h000001, 24'h000000, 1'b1, 1'b1);
    apply(OVP_BASE_UV + OVP_STEP_UV, 24'h000000, 1'b0, 1'b1);
    $display("test voltage limit done");
    wr(8'h01, 8'h00);
    apply(WARN_BASE_UV, 24'h000000, 1'b1, 1'b1);
    apply(WARN_BASE_UV + 24'h000001, 24'h000000, 1'b1, 1'b0);
    wr(8'h01, 8'h80);
    apply(WARN_BASE_UV + 24'h000001, 24'h000000, 1'b1, 1'b1);
    $display("test warning done");
    wr(8'h02, 8'h05);
    apply(LOW_V, 24'h000014 * OCP_STEP_UA - 24'h000001, 1'b1, 1'b1);
    apply(LOW_V, 24'h000014 * OCP_STEP_UA, 1'b0, 1'b1);
    wr(8'h02, 8'h55);
    apply(LOW_V, 24'h000055 * OCP_STEP_UA - 24'h000001, 1'b1, 1'b1);
    apply(LOW_V, 24'h000055 * OCP_STEP_UA, 1'b0, 1'b1);
    wr(8'h02, 8'h80);
    apply(LOW_V, 24'hFFFFFF, 1'b1, 1'b1);
    $display("test current limit done");
    pulse_rst(OVP_DEF, OCP_DEF);
    check({ceb, int_n}, 2'b00, "defaults after register reset");
    pulse_rst(LOW_V, 24'h000000);
    check(int_n, 1'b1, "warning quiet after register reset");
    rdchk(8'h00, 8'h5A);
    rdchk(8'h01, 8'h46);
    rdchk(8'h02, 8'h47);
    $display("test register reset done");
    wr(8'h00, 8'h33);
    nrst = 1'b0;
    repeat (6) @(negedge clk);
    check({ceb, int_n, fet, sw, sda_oe, sda_out}, 6'b010000, "outputs in reset");
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    rdchk(8'h00, 8'h5A);
    $display("test mid-run reset done");
    conclude();
  end
endmodule : battery_protect_threshold_regs_tb
